// [pdi_pad_model.sv]
// pad-side model: resolves each pad from drive enable and outside level
`timescale 1ns/1ps
module pdi_pad_model (
   // from the block
   input wire logic [39:0] i_pad_out,
   input wire logic [39:0] i_pad_oe,
   // outside world
   input wire logic [39:0] i_ext_level,
   input wire logic i_ext_tdi,
   input wire logic i_ext_tdo,
   // to the block
   output logic [39:0] o_pad_level,
   output logic o_tdi,
   output logic o_tdo
);
   // a driven pad reads back its own level, an undriven one the outside
   assign o_pad_level = (i_pad_oe & i_pad_out) | (~i_pad_oe & i_ext_level);
   assign o_tdi = i_ext_tdi;
   assign o_tdo = i_ext_tdo;
endmodule // pdi_pad_model

// [pdi_pkg.sv]
// constants for the pin data and interrupt register block
package pdi_pkg;
   // -------------------------------------------------------------
   // register offsets (byte addresses)
   // -------------------------------------------------------------
   localparam logic [11:0] OFS_PIN_OUT_LOW = 12'h004;
   localparam logic [11:0] OFS_PIN_OUT_LOW_SET = 12'h008;
   localparam logic [11:0] OFS_PIN_OUT_LOW_CLEAR = 12'h00c;
   localparam logic [11:0] OFS_PIN_OUT_HIGH = 12'h010;
   localparam logic [11:0] OFS_PIN_OUT_HIGH_SET = 12'h014;
   localparam logic [11:0] OFS_PIN_OUT_HIGH_CLEAR = 12'h018;
   localparam logic [11:0] OFS_DRIVE_ENABLE_LOW = 12'h020;
   localparam logic [11:0] OFS_DRIVE_ENABLE_LOW_SET = 12'h024;
   localparam logic [11:0] OFS_DRIVE_ENABLE_LOW_CLEAR = 12'h028;
   localparam logic [11:0] OFS_DRIVE_ENABLE_HIGH = 12'h02c;
   localparam logic [11:0] OFS_DRIVE_ENABLE_HIGH_SET = 12'h030;
   localparam logic [11:0] OFS_DRIVE_ENABLE_HIGH_CLEAR = 12'h034;
   localparam logic [11:0] OFS_BOOT_STRAP_CAPTURE = 12'h038;
   localparam logic [11:0] OFS_PAD_LEVEL_LOW = 12'h03c;
   localparam logic [11:0] OFS_PAD_LEVEL_HIGH = 12'h040;
   localparam logic [11:0] OFS_IRQ_PENDING_LOW = 12'h044;
   localparam logic [11:0] OFS_IRQ_PENDING_LOW_SET = 12'h048;
   localparam logic [11:0] OFS_IRQ_PENDING_LOW_CLEAR = 12'h04c;
   localparam logic [11:0] OFS_IRQ_PENDING_HIGH = 12'h050;
   localparam logic [11:0] OFS_IRQ_PENDING_HIGH_SET = 12'h054;
   localparam logic [11:0] OFS_IRQ_PENDING_HIGH_CLEAR = 12'h058;
   localparam logic [11:0] OFS_PER_PIN_CONFIG = 12'h088;
   // -------------------------------------------------------------
   // sizes, fields and reset values
   // -------------------------------------------------------------
   localparam int NUM_PADS = 40;
   localparam int LOW_PADS = 32;
   localparam int HIGH_PADS = 8;
   localparam int CFG_W = 8;
   localparam int CFG_ENA_LSB = 0;
   localparam int CFG_ENA_W = 5;
   localparam int CFG_TRIG_LSB = 5;
   localparam int CFG_TRIG_W = 3;
   localparam logic [31:0] RST_LOW = 32'h0000_0000;
   localparam logic [7:0] RST_HIGH = 8'h00;
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam logic [5:0] RST_STRAP = 6'h00;
   // cycles after reset release until strap capture freezes
   localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;
   // -------------------------------------------------------------
   // trigger select codes
   // -------------------------------------------------------------
   localparam logic [2:0] TRIG_OFF = 3'h0;
   localparam logic [2:0] TRIG_RISE = 3'h1;
   localparam logic [2:0] TRIG_FALL = 3'h2;
   localparam logic [2:0] TRIG_ANY = 3'h3;
   localparam logic [2:0] TRIG_LOW = 3'h4;
   localparam logic [2:0] TRIG_HIGH = 3'h5;
endpackage

// [pdi_regs.sv]
// pin data, drive enable and interrupt pending registers on ahb-lite
// Contract
// RL1: read/write output levels for pads 0-31
// RL2: low output set alias sets written ones
// RL3: low output clear alias clears written ones
// RL4: read/write output levels for pads 32-39
// RL5: high output set/clear aliases act on ones
// RL6: read/write drive enables for pads 0-31
// RL7: low enable set/clear aliases act on ones
// RL8: high drive enables with set/clear aliases
// RL9: strap capture maps six boot pad levels
// RL10: read-only sampled levels of pads 0-31
// RL11: read-only sampled levels of pads 32-39
// RL12: read/write pending bits, pads 0-31
// RL13: software enables per-pin interrupt bits 0-4
// RL14: low pending set alias sets written ones
// RL15: low pending clear alias clears written ones
// RL16: read/write pending bits, pads 32-39
// RL17: high pending set/clear aliases act on ones
// RL18: trigger select picks edge or level condition
// RL19: zero bits untouched, alias reads harmless
`timescale 1ns/1ps
module pdi_regs (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   // ahb-lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // pads
   input wire logic [39:0] i_pad_level,
   input wire logic i_test_data_in_pad,
   input wire logic i_test_data_out_pad,
   output logic [39:0] o_pad_out,
   output logic [39:0] o_pad_oe,
   // interrupt
   output logic o_irq
);
   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] ofs);
      return a[11:2] == ofs[11:2];
   endfunction

   // plain write, set alias or clear alias on one register
   function automatic logic [31:0] upd(input logic [31:0] cur,
                                       input logic rw,
                                       input logic set,
                                       input logic clr,
                                       input logic [31:0] d);
      logic [31:0] r;
      r = cur;
      if (rw) begin
         r = d;
      end else if (set) begin
         r = cur | d;
      end else if (clr) begin
         r = cur & ~d;
      end
      return r;
   endfunction

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   logic [31:0] pin_out_low;
   logic [7:0] pin_out_high_bits;
   logic [31:0] drive_enable_low;
   logic [7:0] drive_enable_high_bits;
   logic [31:0] irq_pending_low;
   logic [7:0] irq_pending_high_bits;
   logic [5:0] boot_strap_capture;
   logic [1:0] strap_settle;
   localparam int CFG_W_L = pdi_pkg::CFG_W;
   logic [CFG_W_L-1:0] per_pin_config [0:pdi_pkg::NUM_PADS-1];
   logic [39:0] pad_s1;
   logic [39:0] pad_s2;
   logic [39:0] pad_s3;
   logic [1:0] tap_s1;
   logic [1:0] tap_s2;
   logic wr_valid;
   logic rd_pend;
   logic [11:0] addr_q;

   // -------------------------------------------------------------
   // bus decode
   // -------------------------------------------------------------
   wire take = i_hsel & i_htrans[1] & i_hready;
   wire [31:0] wd = i_hwdata;
   wire w_out_low = wr_valid & hit(addr_q, pdi_pkg::OFS_PIN_OUT_LOW);
   wire w_out_low_set =
      wr_valid & hit(addr_q, pdi_pkg::OFS_PIN_OUT_LOW_SET);
   wire w_out_low_clr =
      wr_valid & hit(addr_q, pdi_pkg::OFS_PIN_OUT_LOW_CLEAR);
   wire w_out_high = wr_valid & hit(addr_q, pdi_pkg::OFS_PIN_OUT_HIGH);
   wire w_out_high_set =
      wr_valid & hit(addr_q, pdi_pkg::OFS_PIN_OUT_HIGH_SET);
   wire w_out_high_clr =
      wr_valid & hit(addr_q, pdi_pkg::OFS_PIN_OUT_HIGH_CLEAR);
   wire w_oe_low = wr_valid & hit(addr_q, pdi_pkg::OFS_DRIVE_ENABLE_LOW);
   wire w_oe_low_set =
      wr_valid & hit(addr_q, pdi_pkg::OFS_DRIVE_ENABLE_LOW_SET);
   wire w_oe_low_clr =
      wr_valid & hit(addr_q, pdi_pkg::OFS_DRIVE_ENABLE_LOW_CLEAR);
   wire w_oe_high =
      wr_valid & hit(addr_q, pdi_pkg::OFS_DRIVE_ENABLE_HIGH);
   wire w_oe_high_set =
      wr_valid & hit(addr_q, pdi_pkg::OFS_DRIVE_ENABLE_HIGH_SET);
   wire w_oe_high_clr =
      wr_valid & hit(addr_q, pdi_pkg::OFS_DRIVE_ENABLE_HIGH_CLEAR);
   wire w_pend_low = wr_valid & hit(addr_q, pdi_pkg::OFS_IRQ_PENDING_LOW);
   wire w_pend_low_set =
      wr_valid & hit(addr_q, pdi_pkg::OFS_IRQ_PENDING_LOW_SET);
   wire w_pend_low_clr =
      wr_valid & hit(addr_q, pdi_pkg::OFS_IRQ_PENDING_LOW_CLEAR);
   wire w_pend_high =
      wr_valid & hit(addr_q, pdi_pkg::OFS_IRQ_PENDING_HIGH);
   wire w_pend_high_set =
      wr_valid & hit(addr_q, pdi_pkg::OFS_IRQ_PENDING_HIGH_SET);
   wire w_pend_high_clr =
      wr_valid & hit(addr_q, pdi_pkg::OFS_IRQ_PENDING_HIGH_CLEAR);
   wire [11:0] cfg_off = addr_q - pdi_pkg::OFS_PER_PIN_CONFIG;
   wire [5:0] cfg_idx = cfg_off[7:2];
   wire cfg_hit = (addr_q >= pdi_pkg::OFS_PER_PIN_CONFIG) &&
                  (cfg_off[11:2] < 10'd40);
   wire w_cfg = wr_valid & cfg_hit;

   // -------------------------------------------------------------
   // trigger detection on synchronised pad levels
   // -------------------------------------------------------------
   logic [39:0] hw_event;
   logic [39:0] irq_mask;
   always_comb begin
      for (int i = 0; i < pdi_pkg::NUM_PADS; i++) begin
         irq_mask[i] = |per_pin_config[i][pdi_pkg::CFG_ENA_LSB +:
                                          pdi_pkg::CFG_ENA_W];
         unique case (per_pin_config[i][pdi_pkg::CFG_TRIG_LSB +:
                                        pdi_pkg::CFG_TRIG_W])
            pdi_pkg::TRIG_RISE: hw_event[i] = pad_s2[i] & ~pad_s3[i];
            pdi_pkg::TRIG_FALL: hw_event[i] = ~pad_s2[i] & pad_s3[i];
            pdi_pkg::TRIG_ANY: hw_event[i] = pad_s2[i] ^ pad_s3[i];
            pdi_pkg::TRIG_LOW: hw_event[i] = ~pad_s2[i];
            pdi_pkg::TRIG_HIGH: hw_event[i] = pad_s2[i];
            default: hw_event[i] = 1'b0;
         endcase
      end
   end // [RL18]

   // -------------------------------------------------------------
   // next register values
   // -------------------------------------------------------------
   wire [31:0] next_out_low =
      upd(pin_out_low, w_out_low, w_out_low_set, w_out_low_clr, wd);
   wire [31:0] out_high_w = upd({24'h0, pin_out_high_bits}, w_out_high,
                                w_out_high_set, w_out_high_clr, wd);
   wire [31:0] next_oe_low = upd(drive_enable_low, w_oe_low,
                                 w_oe_low_set, w_oe_low_clr, wd);
   wire [31:0] oe_high_w = upd({24'h0, drive_enable_high_bits}, w_oe_high,
                               w_oe_high_set, w_oe_high_clr, wd);
   // hardware events are or-ed in last so a set beats a clear
   wire [31:0] next_pend_low = upd(irq_pending_low, w_pend_low,
                                   w_pend_low_set, w_pend_low_clr, wd) |
                               hw_event[31:0];
   wire [31:0] pend_high_w = upd({24'h0, irq_pending_high_bits},
                                 w_pend_high, w_pend_high_set,
                                 w_pend_high_clr, wd);
   wire [7:0] next_pend_high = pend_high_w[7:0] | hw_event[39:32];
   wire [5:0] next_strap = {tap_s2[0], pad_s2[0], pad_s2[2], pad_s2[4],
                            tap_s2[1], pad_s2[5]};

   // -------------------------------------------------------------
   // read mux; aliases and holes read zero
   // -------------------------------------------------------------
   logic [31:0] rdata;
   always_comb begin
      rdata = 32'h0000_0000;
      if (cfg_hit) begin
         rdata = {24'h0, per_pin_config[cfg_idx]};
      end else begin
         unique case ({addr_q[11:2], 2'b00})
            pdi_pkg::OFS_PIN_OUT_LOW: rdata = pin_out_low;
            pdi_pkg::OFS_PIN_OUT_HIGH: rdata = {24'h0, pin_out_high_bits};
            pdi_pkg::OFS_DRIVE_ENABLE_LOW: rdata = drive_enable_low;
            pdi_pkg::OFS_DRIVE_ENABLE_HIGH:
               rdata = {24'h0, drive_enable_high_bits};
            pdi_pkg::OFS_BOOT_STRAP_CAPTURE:
               rdata = {26'h0, boot_strap_capture};
            pdi_pkg::OFS_PAD_LEVEL_LOW: rdata = pad_s2[31:0];
            pdi_pkg::OFS_PAD_LEVEL_HIGH: rdata = {24'h0, pad_s2[39:32]};
            pdi_pkg::OFS_IRQ_PENDING_LOW: rdata = irq_pending_low;
            pdi_pkg::OFS_IRQ_PENDING_HIGH:
               rdata = {24'h0, irq_pending_high_bits};
            default: rdata = 32'h0000_0000;
         endcase
      end
   end // [RL10] [RL11] [RL19]

   // -------------------------------------------------------------
   // bus slave: writes zero wait, reads one wait state
   // -------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         wr_valid <= 1'b0;
         rd_pend <= 1'b0;
         addr_q <= 12'h000;
         o_hreadyout <= 1'b1;
         o_hrdata <= 32'h0000_0000;
         o_hresp <= 1'b0;
      end else begin
         wr_valid <= take & i_hwrite;
         rd_pend <= take & ~i_hwrite;
         o_hreadyout <= ~(take & ~i_hwrite);
         if (take) begin
            addr_q <= i_haddr[11:0];
         end
         if (rd_pend) begin
            o_hrdata <= rdata;
         end
      end
   end

   // -------------------------------------------------------------
   // pad synchronisers
   // -------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      pad_s1 <= i_pad_level;
      pad_s2 <= pad_s1;
      pad_s3 <= pad_s2;
      tap_s1 <= {i_test_data_out_pad, i_test_data_in_pad};
      tap_s2 <= tap_s1;
   end

   // -------------------------------------------------------------
   // data, enable, pending and strap registers
   // -------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         pin_out_low <= pdi_pkg::RST_LOW;
         pin_out_high_bits <= pdi_pkg::RST_HIGH;
         drive_enable_low <= pdi_pkg::RST_LOW;
         drive_enable_high_bits <= pdi_pkg::RST_HIGH;
         irq_pending_low <= pdi_pkg::RST_LOW;
         irq_pending_high_bits <= pdi_pkg::RST_HIGH;
      end else begin
         pin_out_low <= next_out_low; // [RL1] [RL2] [RL3]
         pin_out_high_bits <= out_high_w[7:0]; // [RL4] [RL5]
         drive_enable_low <= next_oe_low; // [RL6] [RL7]
         drive_enable_high_bits <= oe_high_w[7:0]; // [RL8]
         irq_pending_low <= next_pend_low; // [RL12] [RL14] [RL15]
         irq_pending_high_bits <= next_pend_high; // [RL16] [RL17]
      end
   end

   // strap levels are taken after the synchronisers have filled
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         strap_settle <= 2'h0;
         boot_strap_capture <= pdi_pkg::RST_STRAP;
      end else if (strap_settle != pdi_pkg::STRAP_SETTLE_CYCLES) begin
         strap_settle <= strap_settle + 2'h1;
         boot_strap_capture <= next_strap; // [RL9]
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         for (int i = 0; i < pdi_pkg::NUM_PADS; i++) begin
            per_pin_config[i] <= pdi_pkg::RST_CFG;
         end
      end else if (w_cfg) begin
         per_pin_config[cfg_idx] <= wd[7:0];
      end
   end

   // pending bit reaches the line only if its pin enables it
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |({next_pend_high, next_pend_low} & irq_mask); // [RL13]
      end
   end

   assign o_pad_out = {pin_out_high_bits, pin_out_low};
   assign o_pad_oe = {drive_enable_high_bits, drive_enable_low};

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_reset);

   sequence s_wr(logic [11:0] ofs);
      take && i_hwrite && hit(i_haddr[11:0], ofs);
   endsequence
   sequence s_rd(logic [11:0] ofs);
      take && !i_hwrite && hit(i_haddr[11:0], ofs);
   endsequence

   out_low_rw_a: assert property ( // [RL1]
      s_wr(pdi_pkg::OFS_PIN_OUT_LOW) ##1 1'b1 |=>
         pin_out_low == $past(i_hwdata))
      else $error("output low write not stored");
   out_low_set_a: assert property ( // [RL2]
      s_wr(pdi_pkg::OFS_PIN_OUT_LOW_SET) ##1 1'b1 |=>
         pin_out_low == ($past(pin_out_low) | $past(i_hwdata)))
      else $error("output low set alias wrong");
   out_low_clr_a: assert property ( // [RL3]
      s_wr(pdi_pkg::OFS_PIN_OUT_LOW_CLEAR) ##1 1'b1 |=>
         pin_out_low == ($past(pin_out_low) & ~$past(i_hwdata)))
      else $error("output low clear alias wrong");
   oe_high_set_a: assert property ( // [RL8]
      s_wr(pdi_pkg::OFS_DRIVE_ENABLE_HIGH_SET) ##1 1'b1 |=>
         o_pad_oe[39:32] == ($past(o_pad_oe[39:32]) |
                             $past(i_hwdata[7:0])))
      else $error("high enable set alias wrong");
   pend_clr_a: assert property ( // [RL15]
      s_wr(pdi_pkg::OFS_IRQ_PENDING_LOW_CLEAR) ##1 1'b1 |=>
         irq_pending_low == (($past(irq_pending_low) &
                               ~$past(i_hwdata)) | $past(hw_event[31:0])))
      else $error("pending clear lost an event or missed a bit");
   rise_trig_a: assert property ( // [RL18]
      (per_pin_config[3][pdi_pkg::CFG_TRIG_LSB +: pdi_pkg::CFG_TRIG_W] ==
       pdi_pkg::TRIG_RISE && pad_s2[3] && !pad_s3[3]) |=>
         irq_pending_low[3])
      else $error("rising edge did not set pending bit");
   read_wait_a: assert property (
      take && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
      else $error("read wait state wrong");
   pad_read_a: assert property ( // [RL10]
      s_rd(pdi_pkg::OFS_PAD_LEVEL_LOW) |=> ##1
         o_hrdata == $past(pad_s2[31:0]))
      else $error("pad level read wrong");
   alias_read_a: assert property ( // [RL19]
      s_rd(pdi_pkg::OFS_PIN_OUT_LOW_SET) ##1 1'b1 |=>
         o_hrdata == 32'h0000_0000 && $stable(pin_out_low))
      else $error("alias read not zero or altered state");
   strap_hold_a: assert property ( // [RL9]
      strap_settle == pdi_pkg::STRAP_SETTLE_CYCLES |=>
         $stable(boot_strap_capture))
      else $error("strap capture moved after settle");
   out_high_clr_a: assert property ( // [RL5]
      s_wr(pdi_pkg::OFS_PIN_OUT_HIGH_CLEAR) ##1 1'b1 |=>
         pin_out_high_bits == ($past(pin_out_high_bits) &
                               ~$past(i_hwdata[7:0])))
      else $error("output high clear alias wrong");
   oe_low_clr_a: assert property ( // [RL7]
      s_wr(pdi_pkg::OFS_DRIVE_ENABLE_LOW_CLEAR) ##1 1'b1 |=>
         drive_enable_low == ($past(drive_enable_low) & ~$past(i_hwdata)))
      else $error("low enable clear alias wrong");
   pend_set_a: assert property ( // [RL14]
      s_wr(pdi_pkg::OFS_IRQ_PENDING_LOW_SET) ##1 1'b1 |=>
         irq_pending_low == ($past(irq_pending_low) | $past(i_hwdata) |
                             $past(hw_event[31:0])))
      else $error("pending set alias missed a bit");
   high_pend_clr_a: assert property ( // [RL17]
      s_wr(pdi_pkg::OFS_IRQ_PENDING_HIGH_CLEAR) ##1 1'b1 |=>
         irq_pending_high_bits == (($past(irq_pending_high_bits) &
            ~$past(i_hwdata[7:0])) | $past(hw_event[39:32])))
      else $error("high pending clear alias wrong");
   irq_line_a: assert property ( // [RL13]
      o_irq == |({irq_pending_high_bits, irq_pending_low} &
                 $past(irq_mask)))
      else $error("interrupt line does not follow enabled pending bits");
endmodule // pdi_regs

// [test_pdi_regs.sv]
// self-checking bench for the pin data and interrupt registers
`timescale 1ns/1ps
module test_pdi_regs;
   localparam logic [11:0] BASE [6] = '{pdi_pkg::OFS_PIN_OUT_LOW,
      pdi_pkg::OFS_PIN_OUT_HIGH, pdi_pkg::OFS_DRIVE_ENABLE_LOW,
      pdi_pkg::OFS_DRIVE_ENABLE_HIGH, pdi_pkg::OFS_IRQ_PENDING_LOW,
      pdi_pkg::OFS_IRQ_PENDING_HIGH};
   localparam logic [31:0] MASK [6] = '{32'hffff_ffff, 32'h0000_00ff,
      32'hffff_ffff, 32'h0000_00ff, 32'hffff_ffff, 32'h0000_00ff};
   localparam logic [11:0] CFG3 = pdi_pkg::OFS_PER_PIN_CONFIG + 12'h00c;
   localparam logic [11:0] CFG7 = pdi_pkg::OFS_PER_PIN_CONFIG + 12'h01c;
   localparam logic [11:0] PCLR = pdi_pkg::OFS_IRQ_PENDING_LOW_CLEAR;
   logic i_core_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_hsel = 1'b1;
   logic [31:0] i_haddr = 32'h0;
   logic [1:0] i_htrans = 2'h0;
   logic i_hwrite = 1'b0;
   logic [31:0] i_hwdata = 32'h0;
   logic [39:0] ext_level = 40'h0;
   logic ext_tdi = 1'b1;
   logic ext_tdo = 1'b0;
   wire logic [31:0] o_hrdata;
   wire logic o_hreadyout, o_hresp, o_irq, tdi, tdo;
   wire logic [39:0] o_pad_out, o_pad_oe, pad_level;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;
   logic [31:0] m [6];
   logic [31:0] r;
   logic [39:0] e;
   logic p;

   pdi_regs DUT (.i_core_clk(i_core_clk), .i_reset(i_reset),
      .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
      .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
      .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
      .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
      .i_pad_level(pad_level), .i_test_data_in_pad(tdi),
      .i_test_data_out_pad(tdo), .o_pad_out(o_pad_out),
      .o_pad_oe(o_pad_oe), .o_irq(o_irq));
   pdi_pad_model pads (.i_pad_out(o_pad_out), .i_pad_oe(o_pad_oe),
      .i_ext_level(ext_level), .i_ext_tdi(ext_tdi), .i_ext_tdo(ext_tdo),
      .o_pad_level(pad_level), .o_tdi(tdi), .o_tdo(tdo));

   initial begin
      forever #5 i_core_clk = ~i_core_clk;
   end

   task automatic end_of_test;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         $display("[ERR] %0t bench timeout", $time);
         end_of_test();
      end
   end

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one single ahb-lite transfer, entered just after a rising edge
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      i_haddr <= {20'h0, a};
      i_htrans <= 2'h2;
      i_hwrite <= w;
      @(posedge i_core_clk);
      while (o_hreadyout !== 1'b1) @(posedge i_core_clk);
      i_htrans <= 2'h0;
      i_hwdata <= d;
      @(posedge i_core_clk);
      while (o_hreadyout !== 1'b1) @(posedge i_core_clk);
      q = o_hrdata;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      chk({8'h0, q}, {8'h0, x});
   endtask

   initial begin
      r = $urandom(79);
      @(posedge i_core_clk);
      ext_level <= {8'($urandom()), $urandom()};
      repeat (11) @(posedge i_core_clk);
      i_reset <= 1'b0;
      repeat (5) @(posedge i_core_clk);
      e = ext_level;
      rdc(pdi_pkg::OFS_BOOT_STRAP_CAPTURE,
          {26'h0, ext_tdi, e[0], e[2], e[4], ext_tdo, e[5]});
      $display("test strap done");
      for (int g = 0; g < 6; g++) begin
         r = $urandom();
         m[g] = r & MASK[g];
         wr(BASE[g], r);
         r = $urandom();
         wr(BASE[g] + 12'h004, r);
         m[g] = m[g] | (r & MASK[g]);
         rdc(BASE[g] + 12'h004, 32'h0);
         r = $urandom();
         wr(BASE[g] + 12'h008, r);
         m[g] = m[g] & ~r;
         rdc(BASE[g] + 12'h008, 32'h0);
         rdc(BASE[g], m[g]);
      end
      chk(o_pad_out, {m[1][7:0], m[0]});
      chk(o_pad_oe, {m[3][7:0], m[2]});
      chk({39'h0, o_irq}, 40'h0);
      chk({39'h0, o_hresp}, 40'h0);
      rdc(12'h05c, 32'h0);
      $display("test registers done");
      for (int i = 0; i < 2; i++) begin
         ext_level <= {8'($urandom()), $urandom()};
         repeat (4) @(posedge i_core_clk);
         e = ({m[3][7:0], m[2]} & {m[1][7:0], m[0]}) |
             (~{m[3][7:0], m[2]} & ext_level);
         rdc(pdi_pkg::OFS_PAD_LEVEL_LOW, e[31:0]);
         rdc(pdi_pkg::OFS_PAD_LEVEL_HIGH, {24'h0, e[39:32]});
      end
      $display("test pad levels done");
      wr(PCLR, 32'hffff_ffff);
      wr(pdi_pkg::OFS_IRQ_PENDING_HIGH_CLEAR, 32'hffff_ffff);
      wr(pdi_pkg::OFS_IRQ_PENDING_LOW_SET, 32'h80);
      wr(CFG7, 32'h1);
      repeat (2) @(posedge i_core_clk);
      chk({39'h0, o_irq}, 40'h1);
      wr(PCLR, 32'h80);
      repeat (2) @(posedge i_core_clk);
      chk({39'h0, o_irq}, 40'h0);
      wr(CFG7, 32'h0);
      $display("test interrupt done");
      wr(pdi_pkg::OFS_DRIVE_ENABLE_LOW, 32'h0);
      for (int t = 0; t < 6; t++) begin
         ext_level[3] <= 1'b0;
         repeat (4) @(posedge i_core_clk);
         wr(CFG3, t << 5);
         wr(PCLR, 32'hffff_ffff);
         repeat (4) @(posedge i_core_clk);
         p = (t == 4);
         rdc(pdi_pkg::OFS_IRQ_PENDING_LOW, {28'h0, p, 3'h0});
         ext_level[3] <= 1'b1;
         repeat (5) @(posedge i_core_clk);
         p = p | (t == 1) | (t == 3) | (t == 5);
         rdc(pdi_pkg::OFS_IRQ_PENDING_LOW, {28'h0, p, 3'h0});
         wr(PCLR, 32'h8);
         repeat (4) @(posedge i_core_clk);
         p = (t == 5);
         rdc(pdi_pkg::OFS_IRQ_PENDING_LOW, {28'h0, p, 3'h0});
         ext_level[3] <= 1'b0;
         repeat (5) @(posedge i_core_clk);
         p = p | (t == 2) | (t == 3) | (t == 4);
         rdc(pdi_pkg::OFS_IRQ_PENDING_LOW, {28'h0, p, 3'h0});
      end
      $display("test triggers done");
      end_of_test();
   end
endmodule // test_pdi_regs
